// ===== io_accum_pkg.sv
// constants and types for the i/o read and accumulator command unit
// assumes a 32-bit ahb-lite register bus and a 50 MHz system clock
package io_accum_pkg;
  // instruction codes
  localparam logic [7:0] INSTR_READ_IO = 8'h0F;
  localparam logic [7:0] INSTR_ARITH = 8'h13;
  localparam logic [7:0] INSTR_COMPARE = 8'h14;
  localparam logic [7:0] INSTR_COND_JUMP = 8'h15;
  // reply status codes
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_BAD_CSUM = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
  localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
  // arithmetic operations
  localparam logic [7:0] OP_ADD = 8'h00;
  localparam logic [7:0] OP_SUB = 8'h01;
  localparam logic [7:0] OP_MUL = 8'h02;
  localparam logic [7:0] OP_DIV = 8'h03;
  localparam logic [7:0] OP_MOD = 8'h04;
  localparam logic [7:0] OP_AND = 8'h05;
  localparam logic [7:0] OP_OR = 8'h06;
  localparam logic [7:0] OP_XOR = 8'h07;
  localparam logic [7:0] OP_NOT = 8'h08;
  localparam logic [7:0] OP_LOAD = 8'h09;
  // jump conditions
  localparam logic [7:0] JC_ZERO = 8'h00;
  localparam logic [7:0] JC_NOT_ZERO = 8'h01;
  localparam logic [7:0] JC_EQ = 8'h02;
  localparam logic [7:0] JC_NE = 8'h03;
  localparam logic [7:0] JC_GT = 8'h04;
  localparam logic [7:0] JC_GE = 8'h05;
  localparam logic [7:0] JC_LT = 8'h06;
  localparam logic [7:0] JC_LE = 8'h07;
  // banks and ports
  localparam logic [7:0] BANK_DIG_IN = 8'h00;
  localparam logic [7:0] BANK_ANALOG_IN = 8'h01;
  localparam logic [7:0] BANK_DIG_OUT = 8'h02;
  localparam logic [7:0] PORT_LINE0 = 8'h00;
  localparam logic [7:0] PORT_LINE1 = 8'h01;
  localparam logic [7:0] PORT_SUPPLY = 8'h08;
  localparam logic [7:0] PORT_TEMP = 8'h09;
  localparam logic [7:0] PORT_SHUTDOWN = 8'h0A;
  localparam logic [7:0] PORT_ENC_ZERO = 8'h0B;
  localparam logic [7:0] PORT_ALL_INPUTS = 8'hFF;
  // register byte offsets
  localparam logic [7:0] OFF_CMD_CODE = 8'h00;
  localparam logic [7:0] OFF_CMD_VALUE = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_ADDR = 8'h0C;
  localparam logic [7:0] OFF_ACCUM = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  localparam logic [7:0] OFF_REPLY_HDR = 8'h18;
  localparam logic [7:0] OFF_REPLY_VALUE = 8'h1C;
  localparam logic [7:0] OFF_REPLY_CSUM = 8'h20;
  // field positions
  localparam int FLD_INSTR_LSB = 0;
  localparam int FLD_TYPE_LSB = 8;
  localparam int FLD_BANK_LSB = 16;
  localparam int FLD_CSUM_LSB = 24;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  // reset values
  localparam logic [7:0] HOST_ADDR_RST = 8'h02;
  localparam logic [7:0] TARGET_ADDR_RST = 8'h01;
  // divider step count
  localparam logic [5:0] DIV_STEPS = 6'h20;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DIV, ST_REPLY} cmd_state_e;
endpackage

// ===== div_if.sv
// request and answer signals between the command unit and its divider
// assumes both ends run on the same clock
interface div_if;
  logic start;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic done;
  logic [31:0] quotient;
  logic [31:0] remainder;
  modport requester (output start, output dividend, output divisor, input done, input quotient, input remainder);
  modport unit (input start, input dividend, input divisor, output done, output quotient, output remainder);
endinterface

// ===== signed_divider.sv
// iterative signed 32-bit divider, quotient toward zero, remainder takes dividend sign
// assumes divisor is nonzero; start is ignored while busy
module signed_divider import io_accum_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  div_if.unit dv
);
  logic busy_reg;
  logic done_reg;
  logic [5:0] count_reg;
  logic [31:0] rem_reg;
  logic [31:0] quo_reg;
  logic [31:0] dvs_reg;
  logic neg_q_reg;
  logic neg_r_reg;
  logic [32:0] shifted;
  logic [32:0] trial;
  logic [31:0] dividend_mag;
  logic [31:0] divisor_mag;

  assign dividend_mag = dv.dividend[31] ? (~dv.dividend + 32'h00000001) : dv.dividend;
  assign divisor_mag = dv.divisor[31] ? (~dv.divisor + 32'h00000001) : dv.divisor;
  assign shifted = {rem_reg, quo_reg[31]};
  assign trial = shifted - {1'b0, dvs_reg};
  assign dv.done = done_reg;
  assign dv.quotient = neg_q_reg ? (~quo_reg + 32'h00000001) : quo_reg;
  assign dv.remainder = neg_r_reg ? (~rem_reg + 32'h00000001) : rem_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      count_reg <= 6'h00;
      rem_reg <= 32'h00000000;
      quo_reg <= 32'h00000000;
      dvs_reg <= 32'h00000000;
      neg_q_reg <= 1'b0;
      neg_r_reg <= 1'b0;
    end else if (!busy_reg && dv.start) begin
      busy_reg <= 1'b1;
      done_reg <= 1'b0;
      count_reg <= DIV_STEPS;
      rem_reg <= 32'h00000000;
      quo_reg <= dividend_mag;
      dvs_reg <= divisor_mag;
      neg_q_reg <= dv.dividend[31] ^ dv.divisor[31];
      neg_r_reg <= dv.dividend[31];
    end else if (busy_reg) begin
      // one restoring step per clock
      rem_reg <= trial[32] ? shifted[31:0] : trial[31:0];
      quo_reg <= {quo_reg[30:0], ~trial[32]};
      count_reg <= count_reg - 6'h01;
      busy_reg <= (count_reg != 6'h01);
      done_reg <= (count_reg == 6'h01);
    end else begin
      done_reg <= 1'b0;
    end
  end
endmodule // signed_divider

// ===== io_accum_cmd_unit.sv
// command unit: i/o port read, accumulator arithmetic and compare, over ahb-lite
// assumes the single ahb-lite master, synchronous inputs, one 50 MHz clock
// Contract
// (R1) read-input is code 15; type is port, bank 0 to 2, value ignored
// (R2) digital lines read 0 or 1; converter channels read 0 to 4095
// (R3) in stand-alone mode the read value is copied into the accumulator
// (R4) in direct mode the read value goes to the reply only
// (R5) bank 0 ports 0 and 1 return the two general inputs
// (R6) analog-capable lines read digitally and analog at once, no mode change
// (R7) bank 0 port 255 puts all inputs as bits into accumulator low byte; code packs only the two general inputs, at bits 0 and 1
// (R8) bank 0 port 10 returns the shutdown input state
// (R9) bank 0 port 11 returns encoder near-zero state
// (R10) bank 1: ports 0,1 analog, 8 supply tenths volt, 9 temperature
// (R11) bank 2 ports 0 and 1 read back the two digital outputs
// (R12) arithmetic is code 19; type is operation, bank ignored, value is operand
// (R13) operations 0..9: add sub mul div mod and or xor invert load
// (R14) arithmetic result replaces the accumulator
// (R15) arithmetic and compare meant for stand-alone programs; not enforced
// (R16) compare is code 20; accumulator versus operand sets status flags
// (R17) flags drive conditional jump code 21, conditions 0 to 7
// (R18) direct-mode reply: host, target, status 100, instruction, value, checksum
// (R19) value is 32-bit msb first; checksum is byte sum mod 256
module io_accum_cmd_unit import io_accum_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic general_input_zero,
  input wire logic general_input_one,
  input wire logic shutdown_in,
  input wire logic enc_near_zero,
  input wire logic [11:0] adc_line0,
  input wire logic [11:0] adc_line1,
  input wire logic [15:0] supply_tenths_v,
  input wire logic [15:0] temp_celsius,
  input wire logic general_output_zero,
  input wire logic general_output_one
);
  // bus slave state
  logic wr_pend_reg;
  logic wr_hit_reg;
  logic [7:0] wr_off_reg;
  logic rd_pend_reg;
  logic rd_hit_reg;
  logic [7:0] rd_off_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  // command and result state
  logic [31:0] cmd_code_reg;
  logic [31:0] cmd_value_reg;
  logic [31:0] accum_reg;
  logic [31:0] reply_value_reg;
  logic mode_reg;
  logic [7:0] host_addr_reg;
  logic [7:0] target_addr_reg;
  logic [7:0] status_reg;
  logic [7:0] reply_instr_reg;
  logic [7:0] reply_csum_reg;
  logic reply_valid_reg;
  logic flag_eq_reg;
  logic flag_gt_reg;
  logic flag_lt_reg;
  logic jump_taken_reg;
  cmd_state_e state_reg;
  cmd_state_e state_next;

  div_if div_bus();

  signed_divider u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .dv(div_bus.unit)
  );

  // bus decode
  logic addr_phase;
  logic idle;
  logic wr_ok;
  logic wr_cmd_code;
  logic wr_cmd_value;
  logic wr_ctrl;
  logic wr_addr;
  logic go;
  logic [31:0] rd_data;

  assign addr_phase = hsel & htrans[1] & hready;
  assign idle = (state_reg == ST_IDLE);
  // command registers are locked while a command runs
  assign wr_ok = wr_pend_reg & wr_hit_reg & idle;
  assign wr_cmd_code = wr_ok & (wr_off_reg == OFF_CMD_CODE);
  assign wr_cmd_value = wr_ok & (wr_off_reg == OFF_CMD_VALUE);
  assign wr_ctrl = wr_ok & (wr_off_reg == OFF_CTRL);
  assign wr_addr = wr_ok & (wr_off_reg == OFF_ADDR);
  assign go = wr_ctrl & hwdata[CTRL_GO_BIT];

  assign rd_data = !rd_hit_reg ? 32'h00000000 :
                   (rd_off_reg == OFF_CMD_CODE) ? cmd_code_reg :
                   (rd_off_reg == OFF_CMD_VALUE) ? cmd_value_reg :
                   (rd_off_reg == OFF_CTRL) ? {30'h00000000, mode_reg, ~idle} :
                   (rd_off_reg == OFF_ADDR) ? {16'h0000, target_addr_reg, host_addr_reg} :
                   (rd_off_reg == OFF_ACCUM) ? accum_reg :
                   (rd_off_reg == OFF_FLAGS) ? {28'h0000000, jump_taken_reg, flag_lt_reg, flag_gt_reg, flag_eq_reg} :
                   (rd_off_reg == OFF_REPLY_HDR) ? {reply_instr_reg, status_reg, target_addr_reg, host_addr_reg} :
                   (rd_off_reg == OFF_REPLY_VALUE) ? reply_value_reg :
                   (rd_off_reg == OFF_REPLY_CSUM) ? {23'h000000, reply_valid_reg, reply_csum_reg} :
                   32'h00000000;

  // command fields
  logic [7:0] instr;
  logic [7:0] typ;
  logic [7:0] bank;
  logic [7:0] csum_in;
  logic [31:0] operand;
  logic [7:0] csum_accumulator_arith_cmd;
  logic csum_ok;
  logic standalone;

  assign instr = cmd_code_reg[FLD_INSTR_LSB +: 8];
  assign typ = cmd_code_reg[FLD_TYPE_LSB +: 8];
  assign bank = cmd_code_reg[FLD_BANK_LSB +: 8];
  assign csum_in = cmd_code_reg[FLD_CSUM_LSB +: 8];
  assign operand = cmd_value_reg;
  assign standalone = mode_reg;
  assign csum_accumulator_arith_cmd = target_addr_reg + instr + typ + bank + operand[31:24] + operand[23:16]
                     + operand[15:8] + operand[7:0]; // R19
  // stored programs carry no frame, so only direct frames are checked
  assign csum_ok = standalone | (csum_accumulator_arith_cmd == csum_in); // R19

  logic is_read_io;
  logic is_arith;
  logic is_compare;
  logic is_jump;
  assign is_read_io = (instr == INSTR_READ_IO); // R1
  assign is_arith = (instr == INSTR_ARITH); // R12
  assign is_compare = (instr == INSTR_COMPARE); // R16
  assign is_jump = (instr == INSTR_COND_JUMP); // R17

  // port read selection
  logic bank0_ok;
  logic bank1_ok;
  logic bank2_ok;
  logic [31:0] bank0_val;
  logic [31:0] bank1_val;
  logic [31:0] bank2_val;
  logic io_bank_ok;
  logic io_port_ok;
  logic [31:0] io_value;

  assign bank0_ok = (typ == PORT_LINE0) | (typ == PORT_LINE1) | (typ == PORT_SHUTDOWN)
                    | (typ == PORT_ENC_ZERO) | (typ == PORT_ALL_INPUTS);
  assign bank0_val = (typ == PORT_LINE0) ? {31'h00000000, general_input_zero} : // R5 R6
                     (typ == PORT_LINE1) ? {31'h00000000, general_input_one} : // R5 R6
                     (typ == PORT_SHUTDOWN) ? {31'h00000000, shutdown_in} : // R8
                     (typ == PORT_ENC_ZERO) ? {31'h00000000, enc_near_zero} : // R9
                     {24'h000000, 6'h00, general_input_one, general_input_zero}; // R7
  assign bank1_ok = (typ == PORT_LINE0) | (typ == PORT_LINE1) | (typ == PORT_SUPPLY) | (typ == PORT_TEMP);
  assign bank1_val = (typ == PORT_LINE0) ? {20'h00000, adc_line0} : // R2 R10
                     (typ == PORT_LINE1) ? {20'h00000, adc_line1} : // R2 R10
                     (typ == PORT_SUPPLY) ? {16'h0000, supply_tenths_v} : // R10
                     {{16{temp_celsius[15]}}, temp_celsius}; // R10
  assign bank2_ok = (typ == PORT_LINE0) | (typ == PORT_LINE1);
  assign bank2_val = (typ == PORT_LINE0) ? {31'h00000000, general_output_zero} : // R11
                     {31'h00000000, general_output_one}; // R11
  assign io_bank_ok = (bank == BANK_DIG_IN) | (bank == BANK_ANALOG_IN) | (bank == BANK_DIG_OUT); // R1
  assign io_port_ok = (bank == BANK_DIG_IN) ? bank0_ok : (bank == BANK_ANALOG_IN) ? bank1_ok : bank2_ok;
  assign io_value = (bank == BANK_DIG_IN) ? bank0_val : (bank == BANK_ANALOG_IN) ? bank1_val : bank2_val;

  // accumulator arithmetic
  logic op_ok;
  logic is_divmod;
  logic [31:0] alu_result;

  assign op_ok = (typ <= OP_LOAD); // R13
  assign is_divmod = (typ == OP_DIV) | (typ == OP_MOD); // R13
  assign alu_result = (typ == OP_ADD) ? accum_reg + operand : // R13
                      (typ == OP_SUB) ? accum_reg - operand : // R13
                      (typ == OP_MUL) ? accum_reg * operand : // R13
                      (typ == OP_AND) ? accum_reg & operand : // R13
                      (typ == OP_OR) ? accum_reg | operand : // R13
                      (typ == OP_XOR) ? accum_reg ^ operand : // R13
                      (typ == OP_NOT) ? ~accum_reg : // R13
                      operand; // R13

  // compare and jump conditions
  logic cmp_eq;
  logic cmp_gt;
  logic cmp_lt;
  logic jump_taken;

  assign cmp_eq = (accum_reg == operand); // R16
  assign cmp_gt = ($signed(accum_reg) > $signed(operand)); // R16
  assign cmp_lt = ($signed(accum_reg) < $signed(operand)); // R16
  assign jump_taken = ((typ == JC_ZERO) | (typ == JC_EQ)) ? flag_eq_reg : // R17
                      ((typ == JC_NOT_ZERO) | (typ == JC_NE)) ? ~flag_eq_reg : // R17
                      (typ == JC_GT) ? flag_gt_reg : // R17
                      (typ == JC_GE) ? (flag_gt_reg | flag_eq_reg) : // R17
                      (typ == JC_LT) ? flag_lt_reg : // R17
                      (flag_lt_reg | flag_eq_reg); // R17

  // execution outcome
  logic [7:0] exec_status;
  logic exec_ok;
  logic [31:0] exec_value;
  logic acc_we;
  logic [31:0] acc_val;
  logic div_go;

  assign exec_status = !csum_ok ? STATUS_BAD_CSUM :
                       is_read_io ? (!io_bank_ok ? STATUS_BAD_VALUE : !io_port_ok ? STATUS_BAD_TYPE : STATUS_OK) :
                       is_arith ? (!op_ok ? STATUS_BAD_TYPE :
                                   (is_divmod & (operand == 32'h00000000)) ? STATUS_BAD_VALUE : STATUS_OK) :
                       is_compare ? STATUS_OK :
                       is_jump ? ((typ > JC_LE) ? STATUS_BAD_TYPE : STATUS_OK) :
                       STATUS_BAD_CMD;
  assign exec_ok = (exec_status == STATUS_OK);
  // arithmetic replies with its operand
  assign exec_value = is_read_io ? io_value : is_jump ? {31'h00000000, jump_taken} : operand; // R4
  assign acc_we = exec_ok & ((is_read_io & standalone) | (is_arith & ~is_divmod)); // R3 R4 R14
  assign acc_val = is_read_io ? io_value : alu_result; // R3 R7 R14
  assign div_go = (state_reg == ST_EXEC) & exec_ok & is_arith & is_divmod;

  assign div_bus.start = div_go;
  assign div_bus.dividend = accum_reg;
  assign div_bus.divisor = operand;

  // reply checksum over the finished reply fields
  logic [7:0] reply_csum;
  assign reply_csum = host_addr_reg + target_addr_reg + status_reg + reply_instr_reg + reply_value_reg[31:24]
                      + reply_value_reg[23:16] + reply_value_reg[15:8] + reply_value_reg[7:0]; // R18 R19

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (go) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_next = div_go ? ST_DIV : ST_REPLY;
      end
      ST_DIV: begin
        if (div_bus.done) begin
          state_next = ST_REPLY;
        end
      end
      ST_REPLY: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ahb-lite slave: writes land in the data phase, reads take one wait state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'b0;
      wr_hit_reg <= 1'b0;
      wr_off_reg <= 8'h00;
      rd_pend_reg <= 1'b0;
      rd_hit_reg <= 1'b0;
      rd_off_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      wr_pend_reg <= addr_phase & hwrite;
      rd_pend_reg <= addr_phase & ~hwrite;
      if (addr_phase) begin
        wr_off_reg <= haddr[7:0];
        rd_off_reg <= haddr[7:0];
        wr_hit_reg <= (haddr[31:8] == 24'h000000);
        rd_hit_reg <= (haddr[31:8] == 24'h000000);
      end
      hreadyout_reg <= ~(addr_phase & ~hwrite);
      if (rd_pend_reg) begin
        hrdata_reg <= rd_data;
      end
      hresp_reg <= 1'b0;
    end
  end

  // software-written command registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_code_reg <= 32'h00000000;
      cmd_value_reg <= 32'h00000000;
      mode_reg <= 1'b0;
      host_addr_reg <= HOST_ADDR_RST;
      target_addr_reg <= TARGET_ADDR_RST;
    end else begin
      if (wr_cmd_code) begin
        cmd_code_reg <= hwdata;
      end
      if (wr_cmd_value) begin
        cmd_value_reg <= hwdata;
      end
      if (wr_ctrl) begin
        mode_reg <= hwdata[CTRL_MODE_BIT];
      end
      if (wr_addr) begin
        host_addr_reg <= hwdata[7:0];
        target_addr_reg <= hwdata[15:8];
      end
    end
  end

  // accumulator and flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accum_reg <= 32'h00000000;
      flag_eq_reg <= 1'b0;
      flag_gt_reg <= 1'b0;
      flag_lt_reg <= 1'b0;
      jump_taken_reg <= 1'b0;
    end else if (state_reg == ST_EXEC) begin
      if (acc_we) begin
        accum_reg <= acc_val; // R3 R14
      end
      if (exec_ok & is_compare) begin
        flag_eq_reg <= cmp_eq; // R16
        flag_gt_reg <= cmp_gt; // R16
        flag_lt_reg <= cmp_lt; // R16
      end
      if (exec_ok & is_jump) begin
        jump_taken_reg <= jump_taken; // R17
      end
    end else if ((state_reg == ST_DIV) && div_bus.done) begin
      accum_reg <= (typ == OP_DIV) ? div_bus.quotient : div_bus.remainder; // R13 R14
    end
  end

  // reply fields
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_reg <= 8'h00;
      reply_instr_reg <= 8'h00;
      reply_value_reg <= 32'h00000000;
      reply_csum_reg <= 8'h00;
      reply_valid_reg <= 1'b0;
    end else begin
      if (go) begin
        reply_valid_reg <= 1'b0;
      end
      if (state_reg == ST_EXEC) begin
        status_reg <= exec_status; // R18
        reply_instr_reg <= instr; // R18
        reply_value_reg <= exec_ok ? exec_value : 32'h00000000; // R4
      end
      if (state_reg == ST_REPLY) begin
        reply_csum_reg <= reply_csum; // R18 R19
        reply_valid_reg <= ~standalone; // R18
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
endmodule // io_accum_cmd_unit

// ===== io_accum_checker.sv
// bus-side assertions for the command unit
// assumes binding to io_accum_cmd_unit with hready tied to hreadyout
module io_accum_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd_take;
  logic wr_take;
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  assign wr_take = hsel && htrans[1] && hready && hwrite;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_resp_always_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  a_read_one_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  a_write_no_wait: assert property (wr_take |=> hreadyout) else $error("write stalled");
  a_stall_has_cause: assert property ($fell(hreadyout) |-> $past(rd_take)) else $error("stall without read");
  a_ready_low_once: assert property (!hreadyout |=> hreadyout) else $error("stall too long");
  a_reset_outputs: assert property ($fell(sys_rst) |-> hreadyout && hrdata == 32'h0) else $error("reset outputs");
  a_unmapped_reads_zero: assert property (rd_take && haddr > 32'h20 |-> ##2 hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!$past(rd_take) && !$past(rd_take, 2) |-> $stable(hrdata))
    else $error("read data moved");
endmodule // io_accum_checker

bind io_accum_cmd_unit io_accum_checker u_chk (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// ===== io_lines_model.sv
// i/o lines around the command unit
// assumes the bench sets one pattern byte for all line levels
module io_lines_model (
  input wire logic [7:0] pat,
  output logic general_input_zero,
  output logic general_input_one,
  output logic shutdown_in,
  output logic enc_near_zero,
  output logic general_output_zero,
  output logic general_output_one,
  output logic [11:0] adc_line0,
  output logic [11:0] adc_line1,
  output logic [15:0] supply_tenths_v,
  output logic [15:0] temp_celsius
);
  timeunit 1ns;
  timeprecision 1ns;
  assign general_input_zero = pat[0];
  assign general_input_one = pat[1];
  assign shutdown_in = pat[2];
  assign enc_near_zero = pat[3];
  assign general_output_zero = pat[4];
  assign general_output_one = pat[5];
  assign adc_line0 = {4'hA, pat};
  assign adc_line1 = {pat, 4'h3};
  assign supply_tenths_v = {8'h01, pat};
  assign temp_celsius = {{8{pat[7]}}, pat};
endmodule // io_lines_model

// ===== tb_top.sv
// self-checking bench for the command unit over ahb-lite
// assumes io_lines_model and io_accum_checker are compiled alongside
module tb_top import io_accum_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, hsel, hwrite, hreadyout, hresp, gi0, gi1, sd, ez, go0, go1;
  logic [31:0] haddr, hwdata, hrdata, rv, acc, want, v;
  logic [1:0] htrans;
  logic [2:0] hsize, f;
  logic [7:0] pat;
  logic [11:0] a0, a1;
  logic [15:0] sv, tc;
  logic [15:0] pts [11] = '{16'h0000, 16'h0001, 16'h000A, 16'h000B, 16'h00FF, 16'h0100, 16'h0101, 16'h0108,
    16'h0109, 16'h0200, 16'h0201};
  int mismatches, comparisons;
  io_lines_model u_env (.pat(pat), .general_input_zero(gi0), .general_input_one(gi1), .shutdown_in(sd),
    .enc_near_zero(ez), .general_output_zero(go0), .general_output_one(go1), .adc_line0(a0), .adc_line1(a1),
    .supply_tenths_v(sv), .temp_celsius(tc));
  io_accum_cmd_unit u_dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .general_input_zero(gi0), .general_input_one(gi1), .shutdown_in(sd), .enc_near_zero(ez),
    .adc_line0(a0), .adc_line1(a1), .supply_tenths_v(sv), .temp_celsius(tc), .general_output_zero(go0),
    .general_output_one(go1));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rdc(input string w, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(w, e, q);
  endtask
  task automatic cmd(input logic [7:0] i, t, b, input logic [31:0] d, input logic m);
    logic [7:0] cs;
    logic [31:0] q;
    cs = 8'h01 + i + t + b + d[31:24] + d[23:16] + d[15:8] + d[7:0];
    bus(1'b1, 32'h00, {cs, b, t, i}, q);
    bus(1'b1, 32'h04, d, q);
    bus(1'b1, 32'h08, {30'h0, m, 1'b1}, q);
    q = 32'h1;
    for (int n = 0; n < 60 && q[0] !== 1'b0; n++) bus(1'b0, 32'h08, 32'h0, q);
    chk("busy", 32'h0, {31'h0, q[0]});
  endtask
  task automatic reply(input logic [7:0] i, s, input logic [31:0] d);
    logic [7:0] sum;
    sum = 8'h03 + s + i + d[31:24] + d[23:16] + d[15:8] + d[7:0];
    rdc("reply header", 32'h18, {i, s, 8'h01, 8'h02});
    rdc("reply value", 32'h1C, d);
    rdc("reply checksum", 32'h20, {23'h0, 1'b1, sum});
  endtask
  function automatic logic [31:0] io_exp(input logic [15:0] bp, input logic [7:0] x);
    case (bp)
      16'h0000: return {31'h0, x[0]};
      16'h0001: return {31'h0, x[1]};
      16'h000A: return {31'h0, x[2]};
      16'h000B: return {31'h0, x[3]};
      16'h00FF: return {30'h0, x[1], x[0]};
      16'h0100: return {20'h0, 4'hA, x};
      16'h0101: return {20'h0, x, 4'h3};
      16'h0108: return {16'h0, 8'h01, x};
      16'h0109: return {{24{x[7]}}, x};
      16'h0200: return {31'h0, x[4]};
      default: return {31'h0, x[5]};
    endcase
  endfunction
  function automatic logic [31:0] alu(input logic [7:0] op, input logic [31:0] a, input logic [31:0] d);
    case (op)
      OP_ADD: return a + d;
      OP_SUB: return a - d;
      OP_MUL: return a * d;
      OP_DIV: return $signed(a) / $signed(d);
      OP_MOD: return $signed(a) % $signed(d);
      OP_AND: return a & d;
      OP_OR: return a | d;
      OP_XOR: return a ^ d;
      OP_NOT: return ~a;
      default: return d;
    endcase
  endfunction
  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pat = 8'hB5;
    acc = 32'h0;
    mismatches = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdc("addr reset", 32'h0C, 32'h0000_0102);
    rdc("unmapped", 32'h24, 32'h0);
    bus(1'b1, 32'h10, 32'h1234_5678, rv);
    rdc("accum ro", 32'h10, 32'h0);
    for (int j = 0; j < 2; j++) begin
      pat <= (j == 0) ? 8'hB5 : 8'h4A;
      foreach (pts[k]) begin
        want = io_exp(pts[k], (j == 0) ? 8'hB5 : 8'h4A);
        cmd(INSTR_READ_IO, pts[k][7:0], pts[k][15:8], 32'h77, 1'b0);
        reply(INSTR_READ_IO, STATUS_OK, want);
        rdc("accum direct", 32'h10, acc);
        cmd(INSTR_READ_IO, pts[k][7:0], pts[k][15:8], 32'h0, 1'b1);
        acc = want;
        rdc("accum stand-alone", 32'h10, acc);
      end
    end
    v = 32'hFFFF_FFF9;
    acc = 32'hFFFF_EC78;
    cmd(INSTR_ARITH, OP_LOAD, 8'h00, acc, 1'b0);
    for (int o = 0; o < 10; o++) begin
      acc = alu(8'(o), acc, v);
      cmd(INSTR_ARITH, 8'(o), 8'h5A, v, 1'b0);
      reply(INSTR_ARITH, STATUS_OK, v);
      rdc("accum arith", 32'h10, acc);
    end
    cmd(INSTR_ARITH, OP_DIV, 8'h00, 32'h0, 1'b0);
    reply(INSTR_ARITH, STATUS_BAD_VALUE, 32'h0);
    rdc("accum kept", 32'h10, acc);
    cmd(INSTR_ARITH, 8'h0A, 8'h00, 32'h1, 1'b0);
    reply(INSTR_ARITH, STATUS_BAD_TYPE, 32'h0);
    cmd(8'h16, 8'h00, 8'h00, 32'h0, 1'b0);
    reply(8'h16, STATUS_BAD_CMD, 32'h0);
    for (int c = 0; c < 3; c++) begin
      v = (c == 0) ? 32'hFFFF_FFF9 : (c == 1) ? 32'h5 : 32'hFFFF_FF9C;
      f = (c == 0) ? 3'b001 : (c == 1) ? 3'b100 : 3'b010;
      cmd(INSTR_COMPARE, 8'h33, 8'h44, v, 1'b1);
      for (int t = 0; t < 8; t++) begin
        rv = {24'h0, f[2] | f[0], f[2], f[1] | f[0], f[1], ~f[0], f[0], ~f[0], f[0]};
        want = {28'h0, rv[t], f};
        cmd(INSTR_COND_JUMP, 8'(t), 8'h00, 32'h0A, 1'b1);
        rdc("flags", 32'h14, want);
      end
    end
    stop_test();
  end
endmodule // tb_top
